// [logic/drrc_top.sv]
/*
  Run control and descriptor ring management: section enables, restart,
  fast and flushing suspend, ring geometry and descriptor ownership.
  Assumes one clock, synchronous single-cycle command pulses, and an
  outside engine that reports activity and advances the rings.
*/
// Functional notes
// R1 - mode bits 1 and 0 disable sections
// R2 - report receiver and transmitter on flags
// R3 - errors shut section off until reinit
// R4 - restart reloads descriptor pointers to ring bases
// R5 - host clears ownership before restart
// R6 - host sets suspend bit, polls it
// R7 - feature bit 15 picks fast suspend
// R8 - fast suspend finishes started work only
// R9 - host leaves rings alone while fast suspended
// R10 - flushing suspend drains all queued packets
// R11 - suspend reads one only after completion
// R12 - stop or reset in suspend forces reinit
// R13 - leaving suspend keeps descriptor positions
// R14 - separate contiguous rings, one buffer each
// R15 - legacy style: 8-byte bases, 128 entries
// R16 - legacy style: upper byte on addresses
// R17 - wide styles: 16-byte bases, 512 entries
// R18 - style 3 allows burst descriptor access
// R19 - direct length writes up to 65535
// R20 - only owner writes descriptor fields
// R21 - host reads in order, no lookahead
// R22 - init copies ring bases internally
// R23 - suspend reads zero while entry pending
module drrc_top
  import drrc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        init_done,
  input  wire logic [15:0] mode_register,
  input  wire logic        mode_wr,
  input  wire logic [31:0] tx_ring_base,
  input  wire logic [31:0] rx_ring_base,
  input  wire logic [3:0]  transmit_ring_length_code,
  input  wire logic [3:0]  receive_ring_length_code,
  input  wire logic        tx_len_wr,
  input  wire logic        rx_len_wr,
  input  wire logic [15:0] ring_len_data,
  input  wire logic [15:0] style_config_register,
  input  wire logic [15:0] upper_init_address_register,
  input  wire logic        stop_cmd,
  input  wire logic        start_cmd,
  input  wire logic        memory_error_flag,
  input  wire logic        transmit_underflow_flag,
  input  wire logic        buffer_error_flag,
  input  wire logic        suspend_wr,
  input  wire logic [15:0] extended_control_register,
  input  wire logic [15:0] feature_control_register,
  input  wire logic        tx_active,
  input  wire logic        rx_active,
  input  wire logic        tx_queued,
  input  wire logic        rx_queued,
  input  wire logic        tx_adv,
  input  wire logic        rx_adv,
  input  wire logic        tx_cur_own,
  input  wire logic        rx_cur_own,
  output logic             transmitter_on_flag,
  output logic             receiver_on_flag,
  output logic             suspend_bit,
  output logic             tx_start_ok,
  output logic             rx_accept_ok,
  output logic             dma_start_ok,
  output logic             desc_burst,
  output logic             wide_structure_select,
  output logic             tx_desc_write_ok,
  output logic             rx_desc_write_ok,
  output logic             reinit_required,
  output logic [31:0]      tx_desc_addr,
  output logic [31:0]      rx_desc_addr
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);
  drrc_susp_e  susp_st;
  drrc_susp_e  next_susp_st;
  logic [1:0]  mode_lat;
  logic [31:0] tx_base;
  logic [31:0] rx_base;
  logic [15:0] tx_len;
  logic [15:0] rx_len;
  logic [7:0]  upper;
  logic        stopped;
  logic        wide;
  logic        fast;
  logic        restart;
  logic        drained;
  logic        susp_req;
  logic        susp_clr;
  logic        tx_err;
  logic        rx_err;
  drrc_ring_if tx_rif ();
  drrc_ring_if rx_rif ();
  // ==========================================================
  // decode of command words and style
  assign wide     = (style_config_register[7:0] == STYLE_WIDE) ||
                    (style_config_register[7:0] == STYLE_WIDE_BST);
  assign fast     = feature_control_register[FAST_SUSP_BIT];        // R7
  assign restart  = start_cmd && stopped;                           // R4
  assign susp_req = suspend_wr && extended_control_register[SUSP_BIT];  // R6
  assign susp_clr = suspend_wr && !extended_control_register[SUSP_BIT];
  assign tx_err   = memory_error_flag || transmit_underflow_flag || buffer_error_flag;
  assign rx_err   = memory_error_flag;
  // fast entry waits only for started packets; flushing waits for the queues
  assign drained  = !tx_active && !rx_active && (fast || (!tx_queued && !rx_queued)); // R8 R10
  // ==========================================================
  // ring length from init code, clamped per style, or direct write
  function automatic logic [15:0] code_len(input logic [3:0] code, input logic wd);
    logic [3:0] c;
    c = code;
    if (wd && c > LEN_CODE_MAX_WD) begin
      c = LEN_CODE_MAX_WD;                                          // R17
    end else if (!wd && c > LEN_CODE_MAX_LG) begin
      c = LEN_CODE_MAX_LG;                                          // R15
    end
    code_len = 16'h0001 << c;
  endfunction
  // ==========================================================
  // init copies bases and geometry; direct length writes override
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_base <= BASE_RST;
      rx_base <= BASE_RST;
      tx_len  <= LEN_RST;
      rx_len  <= LEN_RST;
    end else if (ce) begin
      if (init_done) begin
        tx_base <= tx_ring_base;                                    // R22
        rx_base <= rx_ring_base;                                    // R22
        tx_len  <= code_len(transmit_ring_length_code, wide);
        rx_len  <= code_len(receive_ring_length_code, wide);
      end
      if (tx_len_wr) begin
        tx_len <= ring_len_data;                                    // R19
      end
      if (rx_len_wr) begin
        rx_len <= ring_len_data;                                    // R19
      end
    end
  end
  // upper address byte tracks its register, used only in legacy style
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      upper <= 8'h00;
    end else if (ce) begin
      upper <= upper_init_address_register[15:UPPER_LSB];           // R16
    end
  end
  // ==========================================================
  // mode word: latched at init and by every direct write, stopped or not
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_lat <= MODE_RST;
    end else if (ce) begin
      if (init_done || mode_wr) begin
        mode_lat <= {mode_register[TX_DIS_BIT], mode_register[RX_DIS_BIT]}; // R1
      end
    end
  end
  // stop holds until a start or a fresh init
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stopped <= 1'b1;
    end else if (ce) begin
      if (stop_cmd) begin
        stopped <= 1'b1;
      end else if (init_done || start_cmd) begin
        stopped <= 1'b0;
      end
    end
  end
  // ==========================================================
  // section on flags; an error keeps its section off until reinit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      transmitter_on_flag <= 1'b0;
      receiver_on_flag    <= 1'b0;
    end else if (ce) begin
      if (stop_cmd) begin
        transmitter_on_flag <= 1'b0;
        receiver_on_flag    <= 1'b0;
      end else if (init_done) begin
        transmitter_on_flag <= !mode_register[TX_DIS_BIT];           // R1 R2
        receiver_on_flag    <= !mode_register[RX_DIS_BIT];           // R1 R2
      end else if (restart) begin
        transmitter_on_flag <= !mode_lat[1];                         // R1
        receiver_on_flag    <= !mode_lat[0];                         // R1
      end else begin
        if (tx_err) begin
          transmitter_on_flag <= 1'b0;                               // R3
        end
        if (rx_err) begin
          receiver_on_flag <= 1'b0;                                  // R3
        end
      end
    end
  end
  // errors and stop inside suspend leave the block needing init
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reinit_required <= 1'b1;
    end else if (ce) begin
      if (tx_err || rx_err || (stop_cmd && susp_st != DRRC_RUN)) begin
        reinit_required <= 1'b1;                                     // R3 R12
      end else if (init_done || restart) begin
        reinit_required <= 1'b0;
      end
    end
  end
  // ==========================================================
  // suspend sequencing; writes of one are ignored while entry is pending
  always_comb begin
    next_susp_st = susp_st;
    unique case (susp_st)
      DRRC_RUN: begin
        if (susp_req && !stop_cmd) begin
          next_susp_st = DRRC_DRAIN;
        end
      end
      DRRC_DRAIN: begin
        if (stop_cmd || susp_clr) begin
          next_susp_st = DRRC_RUN;
        end else if (drained) begin
          next_susp_st = DRRC_SUSP;                                  // R11 R23
        end
      end
      DRRC_SUSP: begin
        if (stop_cmd || susp_clr) begin
          next_susp_st = DRRC_RUN;                                   // R12 R13
        end
      end
      default: begin
        next_susp_st = DRRC_RUN;
      end
    endcase
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      susp_st     <= DRRC_RUN;
      suspend_bit <= 1'b0;
    end else if (ce) begin
      susp_st     <= next_susp_st;
      suspend_bit <= (next_susp_st == DRRC_SUSP);                   // R11 R23
    end
  end
  // ==========================================================
  // permissions to begin new work, from the coming state
  // flushing entry still lets queued transmits out, but accepts no receives
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_start_ok  <= 1'b0;
      rx_accept_ok <= 1'b0;
      dma_start_ok <= 1'b0;
    end else if (ce) begin
      tx_start_ok  <= (next_susp_st == DRRC_RUN ||
                       (next_susp_st == DRRC_DRAIN && !fast)) && !tx_err; // R8 R10
      rx_accept_ok <= (next_susp_st == DRRC_RUN) && !rx_err;          // R8 R10
      dma_start_ok <= (next_susp_st == DRRC_RUN ||
                       (next_susp_st == DRRC_DRAIN && !fast));        // R8 R10
    end
  end
  // ==========================================================
  // ownership gate: the block writes only descriptors it owns
  // the host side of the handshake is not policed here
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_desc_write_ok <= 1'b0;
      rx_desc_write_ok <= 1'b0;
    end else if (ce) begin
      tx_desc_write_ok <= tx_cur_own && (next_susp_st != DRRC_SUSP); // R20
      rx_desc_write_ok <= rx_cur_own && (next_susp_st != DRRC_SUSP); // R20
    end
  end
  // style outputs for the bus engine
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      desc_burst            <= 1'b0;
      wide_structure_select <= 1'b0;
    end else if (ce) begin
      desc_burst            <= (style_config_register[7:0] == STYLE_WIDE_BST); // R18
      wide_structure_select <= style_config_register[WIDE_SEL_BIT];
    end
  end
  // ==========================================================
  // ring pointers: reload on init or restart, frozen while suspended
  assign tx_rif.reload = init_done || restart;                       // R4 R22
  assign rx_rif.reload = init_done || restart;                       // R4 R22
  assign tx_rif.adv    = tx_adv && susp_st != DRRC_SUSP;             // R13 R14
  assign rx_rif.adv    = rx_adv && susp_st != DRRC_SUSP;             // R13 R14
  assign tx_rif.len    = tx_len;
  assign rx_rif.len    = rx_len;
  drrc_ring_ptr u_tx_ptr (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .rp  (tx_rif)
  );

  drrc_ring_ptr u_rx_ptr (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .rp  (rx_rif)
  );

  drrc_addr_gen u_tx_addr (
    .clk   (clk),
    .rst   (rst),
    .ce    (ce),
    .base  (tx_base),
    .idx   (tx_rif.idx),
    .wide  (wide),
    .upper (upper),
    .addr  (tx_desc_addr)
  );

  drrc_addr_gen u_rx_addr (
    .clk   (clk),
    .rst   (rst),
    .ce    (ce),
    .base  (rx_base),
    .idx   (rx_rif.idx),
    .wide  (wide),
    .upper (upper),
    .addr  (rx_desc_addr)
  );
  // ==========================================================
  // checks
  init_mode_a: assert property ( // R1
    ce && init_done && !stop_cmd |=> transmitter_on_flag == !$past(mode_register[TX_DIS_BIT]))
    else $error("transmitter flag does not follow mode");
  err_off_a: assert property ( // R3
    ce && transmit_underflow_flag && !init_done && !restart |=> !transmitter_on_flag)
    else $error("transmitter stayed on after underflow");
  mem_off_a: assert property ( // R3
    ce && memory_error_flag && !init_done && !restart |=> !receiver_on_flag && !transmitter_on_flag)
    else $error("sections stayed on after memory error");
  restart_reload_a: assert property ( // R4
    ce && restart |=> tx_rif.idx == IDX_RST && rx_rif.idx == IDX_RST)
    else $error("restart did not reload pointers");
  susp_entry_a: assert property ( // R11
    $rose(suspend_bit) |-> $past(susp_st) == DRRC_DRAIN && $past(drained))
    else $error("suspend reported before drain");
  susp_pending_a: assert property ( // R23
    susp_st == DRRC_DRAIN |-> !suspend_bit)
    else $error("suspend read one while pending");
  fast_block_a: assert property ( // R8
    susp_st != DRRC_RUN && fast && $stable(fast) |-> !tx_start_ok && !dma_start_ok)
    else $error("new work allowed in fast suspend");
  flush_rx_a: assert property ( // R10
    susp_st != DRRC_RUN |-> !rx_accept_ok)
    else $error("reception accepted during suspend");
  resume_pos_a: assert property ( // R13
    ce && susp_st == DRRC_SUSP && !tx_rif.reload |=> $stable(tx_rif.idx))
    else $error("pointer moved while suspended");
  burst_style_a: assert property ( // R18
    ce && style_config_register[7:0] == STYLE_WIDE_BST |=> desc_burst)
    else $error("style 3 burst not flagged");
endmodule

// [logic/drrc_pkg.sv]
/*
  Shared constants for descriptor ring run control: mode, suspend and
  style bit positions, ring geometry limits and reset values.
  Assumes a single clock domain and one-word register images on ports.
*/
package drrc_pkg;
  // ==========================================================
  // register bit positions
  localparam int unsigned RX_DIS_BIT    = 0;
  localparam int unsigned TX_DIS_BIT    = 1;
  localparam int unsigned SUSP_BIT      = 0;
  localparam int unsigned FAST_SUSP_BIT = 15;
  localparam int unsigned LOOKAHEAD_BIT = 5;
  localparam int unsigned UPPER_LSB     = 8;
  localparam int unsigned WIDE_SEL_BIT  = 8;
  // ==========================================================
  // software styles and ring geometry
  localparam logic [7:0] STYLE_LEGACY    = 8'h00;
  localparam logic [7:0] STYLE_WIDE      = 8'h02;
  localparam logic [7:0] STYLE_WIDE_BST  = 8'h03;
  localparam logic [3:0] LEN_CODE_MAX_LG = 4'h7;  // 128 entries
  localparam logic [3:0] LEN_CODE_MAX_WD = 4'h9;  // 512 entries
  localparam int unsigned ENTRY_SH_LG    = 3;     // 8 bytes, 8-byte aligned
  localparam int unsigned ENTRY_SH_WD    = 4;     // 16 bytes, 16-byte aligned
  // ==========================================================
  // reset values
  localparam logic [31:0] BASE_RST = 32'h0000_0000;
  localparam logic [15:0] LEN_RST  = 16'h0001;
  localparam logic [15:0] IDX_RST  = 16'h0000;
  localparam logic [1:0]  MODE_RST = 2'h3;        // both sections disabled

  typedef enum logic [1:0] {
    DRRC_RUN   = 2'b00,
    DRRC_DRAIN = 2'b01,
    DRRC_SUSP  = 2'b10
  } drrc_susp_e;
endpackage

// [logic/drrc_ring_if.sv]
/*
  Ring pointer carrier between run control and a ring pointer.
  Assumes the controller owns reload, advance and ring geometry.
*/
interface drrc_ring_if;
  logic        reload;
  logic        adv;
  logic [15:0] len;
  logic [15:0] idx;
  modport ctl (output reload, output adv, output len, input idx);
  modport ptr (input reload, input adv, input len, output idx);
endinterface

// [logic/drrc_ring_ptr.sv]
/*
  Current descriptor index of one ring, wrapping at the ring length.
  Assumes reload and advance are already qualified by the controller.
*/
module drrc_ring_ptr
  import drrc_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  drrc_ring_if.ptr  rp
);
  // ==========================================================
  // index, reload wins over advance
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rp.idx <= IDX_RST;
    end else if (ce) begin
      if (rp.reload) begin
        rp.idx <= IDX_RST;
      end else if (rp.adv) begin
        rp.idx <= (rp.idx + 16'h0001 >= rp.len) ? IDX_RST : rp.idx + 16'h0001; // R19
      end
    end
  end

  idx_in_ring_a: assert property (@(posedge clk) disable iff (rst) // R19
    (rp.idx < rp.len) ##1 $stable(rp.len) |-> rp.idx < rp.len)
    else $error("ring index left the ring");
endmodule

// [logic/drrc_addr_gen.sv]
/*
  Descriptor address for the current ring entry, per software style.
  Assumes base, index and style are stable registers of the controller.
*/
module drrc_addr_gen
  import drrc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic [31:0] base,
  input  wire logic [15:0] idx,
  input  wire logic        wide,
  input  wire logic [7:0]  upper,
  output logic      [31:0] addr
);
  logic [31:0] off;
  logic [31:0] sum;

  // ==========================================================
  // entry size and alignment follow the style; low base bits are dropped
  always_comb begin
    if (wide) begin
      off = {12'h000, idx, 4'h0};                             // R17
      sum = {base[31:4], 4'h0} + off;
    end else begin
      off = {13'h0, idx, 3'h0};                               // R15
      sum = {base[31:3], 3'h0} + off;
    end
  end

  // legacy layout takes the top address byte from the upper init word
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addr <= BASE_RST;
    end else if (ce) begin
      addr <= wide ? sum : {upper, sum[23:0]};                 // R16
    end
  end

  upper_byte_a: assert property (@(posedge clk) disable iff (rst) // R16
    (ce && !wide) |=> addr[31:24] == $past(upper))
    else $error("legacy address lost upper byte");
endmodule

// [test/drrc_host_model.sv]
/*
  Host and system memory stand-in for descriptor ring run control:
  packet activity, queued traffic and ownership of current descriptors.
  Assumes the bench pulses go, give and reclaim for one clock each.
*/
module drrc_host_model (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic go,
  input  wire logic give,
  input  wire logic reclaim,
  output logic      tx_active,
  output logic      rx_active,
  output logic      tx_queued,
  output logic      rx_queued,
  output logic      tx_cur_own,
  output logic      rx_cur_own
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] cnt;
  logic       own;
  // ==========================================================
  // traffic: activity ends well before the queues run dry
  always_ff @(posedge clk or posedge rst) begin
    if (rst) cnt <= 5'h00;
    else if (go) cnt <= 5'h14;
    else if (cnt != 5'h00) cnt <= cnt - 5'h01;
  end
  assign tx_active = cnt > 5'h0e;
  assign rx_active = cnt > 5'h0c;
  assign tx_queued = cnt != 5'h00;
  assign rx_queued = cnt > 5'h04;
  // ==========================================================
  // ownership: one flag for both rings, give sets it, reclaim clears it and wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) own <= 1'b0;
    else if (reclaim) own <= 1'b0;
    else if (give) own <= 1'b1;
  end
  assign tx_cur_own = own;
  assign rx_cur_own = own;
endmodule

// [test/testbench.sv]
/*
  Self-checking bench for descriptor ring run control.
  Assumes the host model drives activity and ownership inputs.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import drrc_pkg::*;
  localparam logic [31:0] TXB = 32'h0012_345c;
  localparam logic [31:0] RXB = 32'h0001_0a04;
  logic        clk = 0, rst = 1, ce = 1, init_done = 0, mode_wr = 0, stop_cmd = 0, start_cmd = 0;
  logic        tx_len_wr = 0, rx_len_wr = 0, suspend_wr = 0, tx_adv = 0, rx_adv = 0;
  logic        memory_error_flag = 0, transmit_underflow_flag = 0, buffer_error_flag = 0;
  logic        go = 0, give = 0, reclaim = 0;
  logic [15:0] mode_register = 0, ring_len_data = 0, style_config_register = 0;
  logic [15:0] upper_init_address_register = 16'h5a00;
  logic [15:0] extended_control_register = 0, feature_control_register = 0;
  logic [31:0] tx_ring_base = TXB, rx_ring_base = RXB;
  logic [3:0]  transmit_ring_length_code = 4'h4, receive_ring_length_code = 4'h4;
  logic        tx_active, rx_active, tx_queued, rx_queued, tx_cur_own, rx_cur_own;
  logic        transmitter_on_flag, receiver_on_flag, suspend_bit, tx_start_ok, rx_accept_ok;
  logic        dma_start_ok, desc_burst, wide_structure_select, tx_desc_write_ok;
  logic        rx_desc_write_ok, reinit_required;
  logic [31:0] tx_desc_addr, rx_desc_addr;
  int          n_errors = 0;
  int          checks = 0;

  always #5 clk = ~clk;

  drrc_top drrc_top_i (.clk, .rst, .ce, .init_done, .mode_register, .mode_wr, .tx_ring_base,
    .rx_ring_base, .transmit_ring_length_code, .receive_ring_length_code, .tx_len_wr, .rx_len_wr,
    .ring_len_data, .style_config_register, .upper_init_address_register, .stop_cmd, .start_cmd,
    .memory_error_flag, .transmit_underflow_flag, .buffer_error_flag, .suspend_wr,
    .extended_control_register, .feature_control_register, .tx_active, .rx_active, .tx_queued,
    .rx_queued, .tx_adv, .rx_adv, .tx_cur_own, .rx_cur_own, .transmitter_on_flag, .receiver_on_flag,
    .suspend_bit, .tx_start_ok, .rx_accept_ok, .dma_start_ok, .desc_burst, .wide_structure_select,
    .tx_desc_write_ok, .rx_desc_write_ok, .reinit_required, .tx_desc_addr, .rx_desc_addr);
  drrc_host_model drrc_host_model_i (.clk, .rst, .go, .give, .reclaim, .tx_active, .rx_active,
    .tx_queued, .rx_queued, .tx_cur_own, .rx_cur_own);

  // ==========================================================
  // helpers: all stimulus moves on the falling edge
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask
  // legacy entries: 8 bytes, top byte from the upper address register
  function automatic logic [31:0] lg(input logic [31:0] b, input logic [15:0] i);
    return {upper_init_address_register[15:8], b[23:3], 3'h0} + {13'h0, i, 3'h0};
  endfunction
  function automatic logic [31:0] wd(input logic [31:0] b, input logic [15:0] i);
    return {b[31:4], 4'h0} + {12'h0, i, 4'h0};
  endfunction
  task automatic boot(input logic [15:0] style);
    style_config_register = style;
    pulse(init_done);
  endtask
  // host takes its descriptors back before every restart
  task automatic restart(input logic [1:0] mode);
    pulse(reclaim);
    pulse(stop_cmd);
    mode_register = {14'h0, mode};
    pulse(mode_wr);
    pulse(start_cmd);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_boot;
    chk(reinit_required, 1, "reinit after reset");
    boot(16'h0000);
    tx_ring_base = 32'h00ff_ff00;  // later changes must not leak in
    restart(2'h0);
    step(3);
    chk(tx_desc_addr, lg(TXB, 0), "latched tx base");
    chk(rx_desc_addr, lg(RXB, 0), "latched rx base");
    chk(wide_structure_select, 0, "legacy select");
    tx_ring_base = TXB;
  endtask
  task automatic t_restart;
    for (int m = 0; m < 4; m++) begin
      restart(m[1:0]);
      chk(transmitter_on_flag, !m[1], "tx on");
      chk(receiver_on_flag, !m[0], "rx on");
      chk(reinit_required, 0, "reinit after restart");
    end
    restart(2'h0);
    repeat (3) pulse(tx_adv);
    pulse(rx_adv);
    step(3);
    chk(tx_desc_addr, lg(TXB, 3), "tx advanced");
    chk(rx_desc_addr, lg(RXB, 1), "rx advanced");
    restart(2'h0);
    step(3);
    chk(tx_desc_addr, lg(TXB, 0), "tx reload");
    chk(rx_desc_addr, lg(RXB, 0), "rx reload");
  endtask
  task automatic t_err;
    for (int e = 0; e < 3; e++) begin
      restart(2'h0);
      case (e)
        0: pulse(transmit_underflow_flag);
        1: pulse(buffer_error_flag);
        default: pulse(memory_error_flag);
      endcase
      step(4);
      chk(transmitter_on_flag, 0, "tx off after error");
      chk(receiver_on_flag, e < 2, "rx after error");
      chk(reinit_required, 1, "reinit after error");
    end
  endtask
  task automatic t_susp(input logic fast);
    int n;
    feature_control_register = {fast, 15'h0};
    restart(2'h0);
    pulse(tx_adv);
    pulse(rx_adv);
    chk(dma_start_ok, 1, "dma allowed in run");
    pulse(go);
    extended_control_register = 16'h0001;
    pulse(suspend_wr);
    chk(suspend_bit, 0, "suspend early");
    chk(rx_accept_ok, 0, "rx accept in drain");
    chk(tx_start_ok, !fast, "tx start in drain");
    chk(dma_start_ok, !fast, "dma in drain");
    pulse(suspend_wr);
    chk(suspend_bit, 0, "repeat suspend write");
    n = 0;
    while (suspend_bit !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk(suspend_bit, 1, "suspend entered");
    chk(tx_active | rx_active, 0, "activity done");
    chk(tx_queued, fast, "queue at entry");
    pulse(tx_adv);
    if (fast) begin
      extended_control_register = 16'h0000;
      pulse(suspend_wr);
      chk(suspend_bit, 0, "suspend left");
      chk(tx_start_ok, 1, "tx back");
      chk(reinit_required, 0, "no reinit");
      step(3);
      chk(tx_desc_addr, lg(TXB, 1), "tx position kept");
      chk(rx_desc_addr, lg(RXB, 1), "rx position kept");
    end else begin
      pulse(stop_cmd);
      chk(reinit_required, 1, "stop in suspend");
      chk(suspend_bit, 0, "stop clears suspend");
    end
  endtask
  task automatic t_own;
    restart(2'h0);
    pulse(give);
    step(1);
    chk(tx_desc_write_ok, 1, "tx owned");
    chk(rx_desc_write_ok, 1, "rx owned");
    ce = 1'b0;
    pulse(reclaim);
    step(1);
    chk(tx_desc_write_ok, 1, "gate frozen by ce");
    ce = 1'b1;
    step(1);
    chk(tx_desc_write_ok, 0, "tx released");
    chk(rx_desc_write_ok, 0, "rx released");
  endtask
  // back-to-back advances up to the last entry, then one wrap
  task automatic t_wrap(input logic [15:0] style, input logic [3:0] code, input logic [15:0] n,
                        input logic direct);
    logic w;
    w = style[7:0] == 8'h02 || style[7:0] == 8'h03;
    transmit_ring_length_code = code;
    boot(style);
    ring_len_data = n;
    if (direct) pulse(tx_len_wr);
    if (direct) pulse(rx_len_wr);
    restart(2'h0);
    chk(desc_burst, style[7:0] == 8'h03, "burst layout");
    chk(wide_structure_select, style[8], "wide select");
    @(negedge clk);
    tx_adv = 1'b1;
    step(n - 16'h1);
    tx_adv = 1'b0;
    step(3);
    chk(tx_desc_addr, w ? wd(TXB, n - 16'h1) : lg(TXB, n - 16'h1), "last entry");
    pulse(tx_adv);
    step(3);
    chk(tx_desc_addr, w ? wd(TXB, 0) : lg(TXB, 0), "ring wrap");
  endtask

  // ==========================================================
  // verdict and main sequence
  task automatic close_out;
    if (n_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    step(10);
    rst = 1'b0;
    t_boot;
    t_restart;
    t_err;
    t_susp(1'b1);
    t_susp(1'b0);
    t_own;
    t_wrap(16'h0000, 4'hf, 16'd128, 1'b0);
    t_wrap(16'h0103, 4'hf, 16'd512, 1'b0);
    t_wrap(16'h0102, 4'h2, 16'd1000, 1'b1);
    close_out;
  end
  // roughly 2000 cycles expected; cut off well beyond
  initial begin
    #100000;
    n_errors++;
    close_out;
  end
endmodule
